/* dv/adc_core_model.sv */
// Behavioural converter core answering start strobes after a set latency
`timescale 1ns/1ps
module adc_core_model (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [2:0] sel,
  input wire logic start,
  input wire logic [7:0] lat,
  output logic done,
  output logic [9:0] result
);
  logic [7:0] cnt_q;
  // ----------------------------------------
  // Zero latency never answers; result churns outside done
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= 8'h00;
      done <= 1'b0;
      result <= 10'h155;
    end else begin
      done <= (cnt_q == 8'h01);
      result <= (cnt_q == 8'h01) ? {sel, 5'h0B, sel[1:0]} : ~result;
      cnt_q <= start ? lat : cnt_q - 8'(cnt_q != 8'h00);
    end
  end
endmodule

/* dv/adc_sequencer_control_props.sv */
// Checker: port-level properties of the converter control block
`timescale 1ns/1ps
module adc_sequencer_control_props (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic standby,
  input wire logic [3:0] bus_addr,
  input wire logic bus_rd,
  input wire logic bus_wr,
  input wire logic [7:0] bus_wdata,
  input wire logic [7:0] bus_rdata,
  input wire logic conv_end_irq,
  input wire logic core_start
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // ----------------------------------------
  // Standby held for a second cycle
  // ----------------------------------------
  sequence s_stby2;
    standby ##1 standby;
  endsequence
  sequence s_stby_rd(logic [3:0] a);
    standby ##1 (standby && bus_rd && bus_addr == a);
  endsequence
  a_ctrl_stby_clear: assert property (s_stby_rd(4'h8) |=> bus_rdata == 8'h00)
    else $error("status not cleared in standby");
  a_trig_stby_reset: assert property (s_stby_rd(4'h9) |=> bus_rdata == 8'h7F)
    else $error("trigger control not reset in standby");
  a_result_stby_clear: assert property (
    standby ##1 (standby && bus_rd && !bus_addr[3]) |=> bus_rdata == 8'h00)
    else $error("result not cleared in standby");
  a_stby_no_start: assert property (s_stby2 |-> !core_start)
    else $error("conversion started in standby");
  a_stby_no_irq: assert property (s_stby2 |-> !conv_end_irq)
    else $error("interrupt active in standby");
  a_irq_enable_gate: assert property (
    bus_wr && bus_addr == 4'h8 && !bus_wdata[6] |=> !conv_end_irq)
    else $error("interrupt active while disabled");
  a_trig_low_ones: assert property (bus_rd && bus_addr == 4'h9 |=> bus_rdata[6:0] == 7'h7F)
    else $error("trigger low bits not ones");
  a_result_low_zero: assert property (
    bus_rd && bus_addr < 4'h8 && bus_addr[0] |=> bus_rdata[5:0] == 6'h00)
    else $error("result low bits not zero");
  a_start_one_cycle: assert property (core_start |=> !core_start)
    else $error("start strobe longer than one cycle");
endmodule
bind adc_sequencer_control adc_sequencer_control_props adc_sequencer_control_props_inst (
  .clk, .rst_b, .standby, .bus_addr, .bus_rd, .bus_wr, .bus_wdata, .bus_rdata,
  .conv_end_irq, .core_start);

/* dv/tb_top.sv */
// Testbench: registers, conversions, trigger, standby and timing
`timescale 1ns/1ps
module tb_top;
  logic clk, rst_b, standby, half_rate, bus_rd, bus_wr, ext_trigger_pin;
  logic conv_end_irq, core_start, core_done;
  logic [3:0] bus_addr;
  logic [7:0] bus_wdata, bus_rdata, d, lat;
  logic [2:0] core_input_select;
  logic [9:0] core_result;
  logic [15:0] rows [8] = '{16'h2080, 16'h69C9, 16'h2282, 16'h6BCB,
    16'h2484, 16'h2D8D, 16'h66C6, 16'h2F8F};
  int n_mismatch = 0;
  int checked = 0;
  int n;
  adc_sequencer_control adc_sequencer_control_inst (.clk, .rst_b, .standby, .half_rate,
    .bus_addr, .bus_rd, .bus_wr, .bus_wdata, .bus_rdata, .ext_trigger_pin, .conv_end_irq,
    .core_input_select, .core_start, .core_done, .core_result);
  adc_core_model adc_core_model_inst (.clk, .rst_b, .sel(core_input_select),
    .start(core_start), .lat, .done(core_done), .result(core_result));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ----------------------------------------
  // Bus and check tasks
  // ----------------------------------------
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    bus_addr <= a;
    bus_wdata <= v;
    bus_wr <= 1'b1;
    @(posedge clk);
    bus_wr <= 1'b0;
  endtask
  task automatic rdc(input logic [3:0] a, input logic [7:0] exp, input string name);
    @(posedge clk);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge clk);
    bus_rd <= 1'b0;
    #1 d = bus_rdata;
    check(name, d, exp);
  endtask
  task automatic wdone();
    n = 0;
    while (core_done !== 1'b1 && n < 400) begin
      @(posedge clk);
      n++;
    end
    check("done seen", 8'(n < 400), 8'h01);
    repeat (2) @(posedge clk);
  endtask
  task automatic tmeas(input logic [7:0] ctl, input int exp);
    wr(4'h8, ctl);
    n = 0;
    while (conv_end_irq !== 1'b1 && n < 700) begin
      @(posedge clk);
      n++;
    end
    check("conv time", 8'(n >= exp && n <= exp + 4), 8'h01);
    rdc(4'h8, ctl ^ 8'hA0, "timed status");
    wr(4'h8, 8'h00);
  endtask
  task automatic stop_test();
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    #300000;
    n_mismatch++;
    stop_test();
  end
  initial begin
    rst_b = 1'b0;
    standby = 1'b0;
    half_rate = 1'b0;
    bus_addr = 4'h0;
    bus_rd = 1'b0;
    bus_wr = 1'b0;
    bus_wdata = 8'h00;
    ext_trigger_pin = 1'b1;
    lat = 8'h05;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    rdc(4'h8, 8'h00, "status reset");
    rdc(4'h9, 8'h7F, "trigger reset");
    rdc(4'h0, 8'h00, "result reset");
    rdc(4'hF, 8'h00, "unmapped");
    $display("test reset done");
    foreach (rows[i]) begin
      wr(4'h8, rows[i][15:8]);
      wdone();
      rdc(4'h8, rows[i][7:0], "status");
      check("irq", 8'(conv_end_irq), 8'(rows[i][6]));
      rdc({1'b0, rows[i][9:8], 1'b0}, {rows[i][10:8], 5'h0B}, "upper");
      rdc({1'b0, rows[i][9:8], 1'b1}, {rows[i][9:8], 6'h00}, "lower");
      wr(4'h8, 8'h00);
    end
    rdc(4'h6, 8'hEB, "upper d");
    rdc(4'h1, 8'hC0, "latch");
    $display("test single rows done");
    wr(4'h8, 8'h21);
    wdone();
    wr(4'h8, 8'h00);
    rdc(4'h8, 8'h80, "no read clear");
    wr(4'h8, 8'h80);
    rdc(4'h8, 8'h80, "write one");
    wr(4'h8, 8'h00);
    rdc(4'h8, 8'h00, "cleared");
    $display("test flag clear done");
    wr(4'h8, 8'h76);
    wdone();
    rdc(4'h8, 8'h76, "scan first");
    wdone();
    wdone();
    rdc(4'h8, 8'hF6, "scan group");
    rdc(4'h0, 8'h8B, "scan a");
    rdc(4'h2, 8'hAB, "scan b");
    rdc(4'h4, 8'hCB, "scan c");
    @(posedge clk);
    standby <= 1'b1;
    rdc(4'h8, 8'h00, "standby status");
    rdc(4'h9, 8'h7F, "standby trigger");
    rdc(4'h2, 8'h00, "standby result");
    @(posedge clk);
    standby <= 1'b0;
    repeat (20) @(posedge clk);
    rdc(4'h8, 8'h00, "scan stopped");
    $display("test scan standby done");
    @(posedge clk);
    lat <= 8'h00;
    wr(4'h9, 8'h80);
    rdc(4'h9, 8'hFF, "trigger on");
    @(posedge clk);
    ext_trigger_pin <= 1'b0;
    repeat (6) @(posedge clk);
    rdc(4'h8, 8'h20, "triggered");
    wr(4'h8, 8'h00);
    ext_trigger_pin <= 1'b1;
    repeat (300) @(posedge clk);
    rdc(4'h8, 8'h00, "aborted");
    wr(4'h9, 8'h00);
    ext_trigger_pin <= 1'b0;
    repeat (6) @(posedge clk);
    rdc(4'h8, 8'h00, "trigger off");
    $display("test trigger done");
    tmeas(8'h68, 134);
    @(posedge clk);
    half_rate <= 1'b1;
    tmeas(8'h60, 532);
    $display("test timing done");
    wr(4'h9, 8'h80);
    wr(4'h8, 8'h76);
    repeat (3) @(posedge clk);
    rst_b <= 1'b0;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    rdc(4'h8, 8'h00, "rerun status");
    rdc(4'h9, 8'h7F, "rerun trigger");
    rdc(4'h0, 8'h00, "rerun result");
    $display("test mid reset done");
    stop_test();
  end
endmodule

/* verilog/adc_conv_timer.sv */
// Conversion timer standing in for the converter core's pacing
`timescale 1ns/1ps
module adc_conv_timer (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clr,
  input wire logic start,
  input wire logic tick,
  input wire logic [adc_ctl_pkg::CONV_CNT_W-1:0] length,
  output logic busy,
  output logic expired
);
  typedef struct packed {
    logic run;
    logic [adc_ctl_pkg::CONV_CNT_W-1:0] cnt;
  } tmr_t;
  tmr_t t_q;
  tmr_t t_d;

  always_comb begin
    t_d = t_q;
    if (clr) begin
      t_d.run = 1'b0;
      t_d.cnt = '0;
    end else if (start) begin
      t_d.run = 1'b1;
      t_d.cnt = length;
    end else if (t_q.run && tick) begin
      if (t_q.cnt <= 1) begin
        t_d.run = 1'b0;
      end
      t_d.cnt = t_q.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      t_q <= '0;
    end else begin
      t_q <= t_d;
    end
  end

  assign busy = t_q.run;
  assign expired = t_q.run & tick & (t_q.cnt <= 1) & ~clr;
endmodule

/* verilog/adc_ctl_pkg.sv */
// Package: register map, field positions, reset values and timing of the converter control
package adc_ctl_pkg;
  // ----------------------------------------
  // Register addresses (low nibble of the byte bus address)
  // ----------------------------------------
  localparam logic [3:0] ADDR_RESULT_A_HI = 4'h0;
  localparam logic [3:0] ADDR_RESULT_D_LO = 4'h7;
  localparam logic [3:0] ADDR_CTRL_STATUS = 4'h8;
  localparam logic [3:0] ADDR_TRIG_CTRL = 4'h9;
  // ----------------------------------------
  // Control/status field positions
  // ----------------------------------------
  localparam int END_FLAG_POS = 7;
  localparam int IRQ_EN_POS = 6;
  localparam int START_POS = 5;
  localparam int MODE_POS = 4;
  localparam int SPEED_POS = 3;
  localparam int GROUP_POS = 2;
  localparam int TRIG_EN_POS = 7;
  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] CTRL_STATUS_RESET = 8'h00;
  localparam logic [7:0] TRIG_CTRL_RESET = 8'h7F;
  localparam logic [7:0] TRIG_CTRL_FILL = 8'h7F;
  localparam logic [15:0] RESULT_RESET = 16'h0000;
  // ----------------------------------------
  // Conversion time, in states at full peripheral clock
  // ----------------------------------------
  localparam int CONV_STATES_SLOW = 266;
  localparam int CONV_STATES_FAST = 134;
  localparam int CONV_CNT_W = 10;
  localparam logic [CONV_CNT_W-1:0] CONV_CYC_SLOW = CONV_CNT_W'(CONV_STATES_SLOW);
  localparam logic [CONV_CNT_W-1:0] CONV_CYC_FAST = CONV_CNT_W'(CONV_STATES_FAST);
endpackage

/* verilog/adc_edge_sync.sv */
// Two-flop synchroniser with falling-edge detect for the trigger pin
`timescale 1ns/1ps
module adc_edge_sync (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic pin,
  output logic fall
);
  typedef struct packed {
    logic meta;
    logic sync;
    logic last;
  } sync_t;
  sync_t s_q;
  sync_t s_d;

  always_comb begin
    s_d = s_q;
    s_d.meta = pin;
    s_d.sync = s_q.meta;
    s_d.last = s_q.sync;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '{meta: 1'b1, sync: 1'b1, last: 1'b1};
    end else begin
      s_q <= s_d;
    end
  end

  assign fall = s_q.last & ~s_q.sync;
endmodule

/* verilog/adc_sequencer_control.sv */
// Control, status and result registers of the 10-bit converter
`timescale 1ns/1ps
// How it works
// - Control/status clears on reset and standby
// - End flag after single or whole group
// - Flag clears by read-one then write-zero
// - Interrupt request only while enable set
// - Start reads one, self-clears in single
// - Multi-channel mode cycles until start cleared
// - Trigger pin may also set start
// - Mode bit: zero single, one cyclic
// - Speed bit picks 266 or 134 states
// - Channel field picks input or group range
// - Trigger control resets to 0x7F
// - Trigger enable gates the external trigger
// - Low seven trigger bits read one
// - Upper byte read captures lower into latch
// - Lower byte read returns holding latch
// - Result left-justified, low six bits zero
// - Input n stores to result n mod 4
// - Trigger falling edge acts as software start
// - Result registers clear on reset, standby
module adc_sequencer_control (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic standby,
  input wire logic half_rate,
  input wire logic [3:0] bus_addr,
  input wire logic bus_rd,
  input wire logic bus_wr,
  input wire logic [7:0] bus_wdata,
  output logic [7:0] bus_rdata,
  input wire logic ext_trigger_pin,
  output logic conv_end_irq,
  output logic [2:0] core_input_select,
  output logic core_start,
  input wire logic core_done,
  input wire logic [9:0] core_result
);
  typedef struct packed {
    logic conv_end_flag;
    logic end_irq_enable;
    logic conv_start_bit;
    logic mode_multi;
    logic conv_speed_select;
    logic [2:0] input_select;
    logic ext_trigger_enable;
    logic flag_seen;
    logic [1:0] cur_index;
    logic active;
    logic div_phase;
    logic [3:0][9:0] result_regs;
    logic [7:0] hold_latch;
    logic [7:0] rdata;
  } ctl_t;
  ctl_t c_q;
  ctl_t c_d;

  logic trig_fall;
  logic tick;
  logic launch;
  logic timer_busy;
  logic timer_expired;
  logic conv_done;
  logic stop;
  logic [adc_ctl_pkg::CONV_CNT_W-1:0] conv_len;
  logic [7:0] csr_view;
  logic [15:0] result_word [4];

  // ----------------------------------------
  // Trigger pin and conversion pacing
  // ----------------------------------------
  adc_edge_sync u_trig (
    .clk(clk),
    .rst_b(rst_b),
    .pin(ext_trigger_pin),
    .fall(trig_fall)
  );

  // Half-rate peripheral clock doubles the timer's conversion time; a core done strobe is not slowed
  assign tick = ~half_rate | c_q.div_phase;
  assign conv_len = c_q.conv_speed_select ? adc_ctl_pkg::CONV_CYC_FAST
                                          : adc_ctl_pkg::CONV_CYC_SLOW;
  assign stop = ~c_q.conv_start_bit | standby;

  adc_conv_timer u_timer (
    .clk(clk),
    .rst_b(rst_b),
    .clr(stop),
    .start(launch),
    .tick(tick),
    .length(conv_len),
    .busy(timer_busy),
    .expired(timer_expired)
  );

  // Core finishes on its done strobe or when the time runs out
  assign conv_done = c_q.active & ~stop & (core_done | timer_expired);
  assign launch = c_q.conv_start_bit & ~c_q.active & ~standby;
  assign core_start = launch;

  // Single mode: field picks input; multi: group base plus running index
  always_comb begin
    if (c_q.mode_multi) begin
      core_input_select = {c_q.input_select[2], c_q.cur_index};
    end else begin
      core_input_select = c_q.input_select;
    end
  end

  // ----------------------------------------
  // Register views
  // ----------------------------------------
  always_comb begin
    csr_view = {c_q.conv_end_flag, c_q.end_irq_enable, c_q.conv_start_bit, c_q.mode_multi,
                c_q.conv_speed_select, c_q.input_select};
    for (int i = 0; i < 4; i++) begin
      result_word[i] = {c_q.result_regs[i], 6'h00};
    end
  end

  assign conv_end_irq = c_q.conv_end_flag & c_q.end_irq_enable;
  assign bus_rdata = c_q.rdata;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    c_d = c_q;
    c_d.div_phase = ~c_q.div_phase;
    c_d.rdata = 8'h00;

    // Reads: data registered one cycle after the strobe
    if (bus_rd) begin
      if (bus_addr <= adc_ctl_pkg::ADDR_RESULT_D_LO) begin
        if (bus_addr[0] == 1'b0) begin
          c_d.rdata = result_word[bus_addr[2:1]][15:8];
          c_d.hold_latch = result_word[bus_addr[2:1]][7:0];
        end else begin
          c_d.rdata = c_q.hold_latch;
        end
      end else if (bus_addr == adc_ctl_pkg::ADDR_CTRL_STATUS) begin
        c_d.rdata = csr_view;
        if (c_q.conv_end_flag) begin
          c_d.flag_seen = 1'b1;
        end
      end else if (bus_addr == adc_ctl_pkg::ADDR_TRIG_CTRL) begin
        c_d.rdata = {c_q.ext_trigger_enable, 7'h7F} & {1'b1, adc_ctl_pkg::TRIG_CTRL_FILL[6:0]};
      end
    end

    // Writes
    if (bus_wr && bus_addr == adc_ctl_pkg::ADDR_CTRL_STATUS) begin
      c_d.end_irq_enable = bus_wdata[adc_ctl_pkg::IRQ_EN_POS];
      c_d.conv_start_bit = bus_wdata[adc_ctl_pkg::START_POS];
      c_d.mode_multi = bus_wdata[adc_ctl_pkg::MODE_POS];
      c_d.conv_speed_select = bus_wdata[adc_ctl_pkg::SPEED_POS];
      c_d.input_select = bus_wdata[2:0];
      if (!bus_wdata[adc_ctl_pkg::END_FLAG_POS] && c_q.flag_seen) begin
        c_d.conv_end_flag = 1'b0;
        c_d.flag_seen = 1'b0;
      end
      if (!bus_wdata[adc_ctl_pkg::START_POS]) begin
        c_d.active = 1'b0;
        c_d.cur_index = 2'b00;
      end
    end
    if (bus_wr && bus_addr == adc_ctl_pkg::ADDR_TRIG_CTRL) begin
      c_d.ext_trigger_enable = bus_wdata[adc_ctl_pkg::TRIG_EN_POS];
    end

    // External trigger behaves as a software start
    if (trig_fall && c_q.ext_trigger_enable) begin
      c_d.conv_start_bit = 1'b1;
    end

    // Conversion sequencing
    if (launch) begin
      c_d.active = 1'b1;
    end
    if (conv_done) begin
      c_d.result_regs[core_input_select[1:0]] = core_result;
      if (!c_q.mode_multi) begin
        c_d.active = 1'b0;
        c_d.conv_start_bit = 1'b0;
        c_d.conv_end_flag = 1'b1;
        c_d.flag_seen = 1'b0;
      end else if (c_q.cur_index == c_q.input_select[1:0]) begin
        c_d.active = 1'b0;
        c_d.cur_index = 2'b00;
        c_d.conv_end_flag = 1'b1;
        c_d.flag_seen = 1'b0;
      end else begin
        c_d.active = 1'b0;
        c_d.cur_index = c_q.cur_index + 2'b01;
      end
    end

    // Stop in the launch cycle must not leave a stale active flag
    if (!c_d.conv_start_bit) begin
      c_d.active = 1'b0;
      c_d.cur_index = 2'b00;
    end

    // Standby returns all registers except div_phase and rdata to their reset contents
    if (standby) begin
      c_d.conv_end_flag = 1'b0;
      c_d.end_irq_enable = 1'b0;
      c_d.conv_start_bit = 1'b0;
      c_d.mode_multi = 1'b0;
      c_d.conv_speed_select = 1'b0;
      c_d.input_select = 3'h0;
      c_d.flag_seen = 1'b0;
      c_d.cur_index = 2'b00;
      c_d.active = 1'b0;
      c_d.ext_trigger_enable = adc_ctl_pkg::TRIG_CTRL_RESET[adc_ctl_pkg::TRIG_EN_POS];
      for (int i = 0; i < 4; i++) begin
        c_d.result_regs[i] = adc_ctl_pkg::RESULT_RESET[15:6];
      end
      c_d.hold_latch = 8'h00;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      c_q <= '0;
      c_q.ext_trigger_enable <= adc_ctl_pkg::TRIG_CTRL_RESET[7];
    end else begin
      c_q <= c_d;
    end
  end
endmodule
